/* mcbp_pkg.sv */
// Constants and state type for the master CPU slave bus port
`default_nettype none
package mcbp_pkg;
  // ----------------------------------------------------------------
  // Widths and pin sampling layout
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int SW = 13;
  localparam int P_WN = 0;
  localparam int P_RN = 1;
  localparam int P_CS0 = 2;
  localparam int P_CS1 = 3;
  localparam int P_A0 = 4;
  localparam int P_D = 5;
  localparam int FDEPTH = 2;
  // ----------------------------------------------------------------
  // Local register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] R_STAT0 = 3'h0;
  localparam logic [2:0] R_STAT1 = 3'h1;
  localparam logic [2:0] R_INB0 = 3'h2;
  localparam logic [2:0] R_INB1 = 3'h3;
  localparam logic [2:0] R_CTRL0 = 3'h4;
  localparam logic [2:0] R_CTRL1 = 3'h5;
  localparam logic [2:0] R_PCTRL = 3'h6;
  // ----------------------------------------------------------------
  // Field positions, status flag mask and buffer full count
  // ----------------------------------------------------------------
  localparam int B_EN = 7;
  localparam int B_DBL = 7;
  localparam int B_RWM = 0;
  localparam int B_TTL = 7;
  localparam int S_OBF = 0;
  localparam int S_IBF = 1;
  localparam int S_A0 = 3;
  localparam logic [7:0] USR_MASK = 8'hF4;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // ----------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SW-1:0] s1, s2, s3, f;
    logic en, dbl, rwm, ttl;
    logic [7:0] u0, u1, ob0, ob1, ib0, ib1;
    logic [1:0] obf, ibf, a0l;
    logic [9:0] fq0, fq1;
    logic [1:0] cnt;
    logic rdp, rset, ra0, wrp, wset, wa0;
    logic [7:0] wd, dout;
    logic doe, rdy;
    logic [1:0] ibirq, obirq;
    logic [7:0] rdata;
  } mcbp_state_t;
endpackage : mcbp_pkg
`default_nettype wire

/* mcbp_port.sv */
// Slave parallel port between an external master CPU and local firmware
`default_nettype none
// What this block does
// - Two in/out buffer sets sharing one input queue, run by master strobes and firmware accesses.
// - Serves separate read/write strobes or a single R/W line with strobe.
// - Control register zero bit 7 enables the slave port.
// - Control register one bit 7 picks double mode; second select used.
// - Firmware sets Port 6 to input before enabling the port.
// - Each master write accepted into the queue raises an input-full request; writes arriving at a full queue are dropped.
// - Each master data read raises an output-empty request.
// - Data pins are a three-state bus; strobes and selects are inputs.
// - Transfers may be serviced by firmware or by the DMA controller.
// - Input threshold is CMOS by default; port control bit 7 picks TTL.
// - Status bits 0,1,3 are hardware read-only; 2,4-7 are firmware flags.
// - Master read with register select high returns the status register.
// - Output-full sets on firmware write, clears on master data read.
// - Input-full sets on master write, clears on firmware input buffer read.
// - Each master write accepted into the queue latches the register-select level into the set.
// - Master write latches the data bus into the selected input buffer.
// - Firmware reads each input buffer through its own register.
// - Master read with register select low returns the output buffer.
// - Status bit 0 output-full, bit 1 input-full, bit 3 latched select.
module mcbp_port #(
  parameter int DATA_W = mcbp_pkg::DW,
  parameter int BUF_DEPTH = mcbp_pkg::FDEPTH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic write_n_in,
  input wire logic read_n_in,
  input wire logic chip_select_first_n_in,
  input wire logic chip_select_second_n_in,
  input wire logic register_select_line_in,
  input wire logic [7:0] host_data_pins_in,
  output logic [7:0] host_data_pins_out,
  output logic host_data_pins_oe_out,
  output logic host_ready_out,
  input wire logic [2:0] fw_addr_in,
  input wire logic fw_wr_in,
  input wire logic fw_rd_in,
  input wire logic [7:0] fw_wdata_in,
  output logic [7:0] fw_rdata_out,
  output logic [1:0] inbound_full_irq_out,
  output logic [1:0] outbound_empty_irq_out,
  output logic master_bus_port_en_out,
  output logic second_select_port_pin_used_out,
  output logic input_threshold_select_out
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8 || BUF_DEPTH != 2) begin : g_bad
    $error("mcbp_port supports only 8-bit data and a 2-entry buffer");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  mcbp_pkg::mcbp_state_t q;
  mcbp_pkg::mcbp_state_t n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic sel0;
    logic sel1;
    logic hset;
    logic stb;
    logic rd;
    logic wr;
    logic push;
    logic pop;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [9:0] nw;
    sel0 = 1'b0;
    sel1 = 1'b0;
    hset = 1'b0;
    stb = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    st0 = 8'h00;
    st1 = 8'h00;
    nw = 10'h000;
    n = q;
    n.ibirq = 2'h0;
    n.obirq = 2'h0;
    // Pins pass three stages; a change counts once stages 2 and 3 agree
    n.s1 = {host_data_pins_in, register_select_line_in,
            chip_select_second_n_in, chip_select_first_n_in,
            read_n_in, write_n_in};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < mcbp_pkg::SW; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.f[i] = q.s2[i];
      end
    end
    // Select decode: second select only counts in double mode
    sel0 = q.en & ~q.f[mcbp_pkg::P_CS0];
    sel1 = q.en & q.dbl & ~q.f[mcbp_pkg::P_CS1];
    hset = ~sel0;
    // R/W style master: write_n is the strobe, read_n the direction
    stb = q.rwm ? ~q.f[mcbp_pkg::P_WN] : 1'b1;
    if (q.rwm) begin
      rd = (sel0 | sel1) & stb & q.f[mcbp_pkg::P_RN];
      wr = (sel0 | sel1) & stb & ~q.f[mcbp_pkg::P_RN];
    end else begin
      rd = (sel0 | sel1) & ~q.f[mcbp_pkg::P_RN];
      wr = (sel0 | sel1) & ~q.f[mcbp_pkg::P_WN];
    end
    // Status words: hardware flags over masked firmware flags
    st0 = q.u0;
    st0[mcbp_pkg::S_OBF] = q.obf[0];
    st0[mcbp_pkg::S_IBF] = q.ibf[0];
    st0[mcbp_pkg::S_A0] = q.a0l[0];
    st1 = q.u1;
    st1[mcbp_pkg::S_OBF] = q.obf[1];
    st1[mcbp_pkg::S_IBF] = q.ibf[1];
    st1[mcbp_pkg::S_A0] = q.a0l[1];
    // Master read: drive only while selected and reading
    n.doe = rd;
    if (q.f[mcbp_pkg::P_A0]) begin
      n.dout = hset ? st1 : st0;
    end else begin
      n.dout = hset ? q.ob1 : q.ob0;
    end
    if (rd && !q.rdp) begin
      n.rset = hset;
      n.ra0 = q.f[mcbp_pkg::P_A0];
    end
    n.rdp = rd;
    // End of a data read empties the buffer; clear goes before sets
    if (q.rdp && !rd && !q.ra0) begin
      n.obf[q.rset] = 1'b0;
      n.obirq[q.rset] = 1'b1;
    end
    // Master write: keep the last sampled bus until the strobe ends
    if (wr) begin
      n.wset = hset;
      n.wa0 = q.f[mcbp_pkg::P_A0];
      n.wd = q.f[mcbp_pkg::P_D +: 8];
    end
    n.wrp = wr;
    // Writes landing on a full buffer are dropped; host_ready warns
    push = q.wrp & ~wr & (q.cnt != mcbp_pkg::FIFO_FULL);
    nw = {q.wset, q.wa0, q.wd};
    // Firmware side of the register file
    n.rdata = 8'h00;
    if (fw_rd_in) begin
      unique case (fw_addr_in)
        mcbp_pkg::R_STAT0: n.rdata = st0;
        mcbp_pkg::R_STAT1: n.rdata = st1;
        mcbp_pkg::R_INB0: begin
          n.rdata = q.ib0;
          n.ibf[0] = 1'b0;
        end
        mcbp_pkg::R_INB1: begin
          n.rdata = q.ib1;
          n.ibf[1] = 1'b0;
        end
        mcbp_pkg::R_CTRL0: n.rdata[mcbp_pkg::B_EN] = q.en;
        mcbp_pkg::R_CTRL1: begin
          n.rdata[mcbp_pkg::B_DBL] = q.dbl;
          n.rdata[mcbp_pkg::B_RWM] = q.rwm;
        end
        mcbp_pkg::R_PCTRL: n.rdata[mcbp_pkg::B_TTL] = q.ttl;
        default: n.rdata = 8'h00;
      endcase
    end
    if (fw_wr_in) begin
      unique case (fw_addr_in)
        mcbp_pkg::R_STAT0: n.u0 = fw_wdata_in & mcbp_pkg::USR_MASK;
        mcbp_pkg::R_STAT1: n.u1 = fw_wdata_in & mcbp_pkg::USR_MASK;
        mcbp_pkg::R_INB0: begin
          n.ob0 = fw_wdata_in;
          n.obf[0] = 1'b1;
        end
        mcbp_pkg::R_INB1: begin
          n.ob1 = fw_wdata_in;
          n.obf[1] = 1'b1;
        end
        // Port 6 must already be input before this bit is set
        mcbp_pkg::R_CTRL0: n.en = fw_wdata_in[mcbp_pkg::B_EN];
        mcbp_pkg::R_CTRL1: begin
          n.dbl = fw_wdata_in[mcbp_pkg::B_DBL];
          n.rwm = fw_wdata_in[mcbp_pkg::B_RWM];
        end
        mcbp_pkg::R_PCTRL: n.ttl = fw_wdata_in[mcbp_pkg::B_TTL];
        default: n.en = q.en;
      endcase
    end
    // Buffer head moves into its input register once that one is empty
    pop = (q.cnt != 2'h0) & ~q.ibf[q.fq0[9]];
    if (pop) begin
      if (q.fq0[9]) begin
        n.ib1 = q.fq0[7:0];
      end else begin
        n.ib0 = q.fq0[7:0];
      end
      n.a0l[q.fq0[9]] = q.fq0[8];
      n.ibf[q.fq0[9]] = 1'b1;
      n.ibirq[q.fq0[9]] = 1'b1;
    end
    // Two-entry buffer bookkeeping
    unique case ({push, pop})
      2'b10: begin
        if (q.cnt == 2'h0) begin
          n.fq0 = nw;
        end else begin
          n.fq1 = nw;
        end
        n.cnt = q.cnt + 2'h1;
      end
      2'b01: begin
        n.fq0 = q.fq1;
        n.cnt = q.cnt - 2'h1;
      end
      2'b11: begin
        if (q.cnt == 2'h1) begin
          n.fq0 = nw;
        end else begin
          n.fq0 = q.fq1;
          n.fq1 = nw;
        end
      end
      2'b00: n.cnt = q.cnt;
    endcase
    n.rdy = (n.cnt != mcbp_pkg::FIFO_FULL);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign host_data_pins_out = q.dout;
  assign host_data_pins_oe_out = q.doe;
  assign host_ready_out = q.rdy;
  assign fw_rdata_out = q.rdata;
  assign inbound_full_irq_out = q.ibirq;
  assign outbound_empty_irq_out = q.obirq;
  assign master_bus_port_en_out = q.en;
  assign second_select_port_pin_used_out = q.dbl;
  assign input_threshold_select_out = q.ttl;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  property p_oe_off;
    !q.en |=> !host_data_pins_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data bus driven while port disabled");

  property p_obf_set;
    fw_wr_in && fw_addr_in == mcbp_pkg::R_INB0 |=> q.obf[0];
  endproperty
  a_obf_set: assert property (p_obf_set)
    else $error("output full not set by firmware write");

  property p_obirq;
    outbound_empty_irq_out[0] |-> $past(q.rdp) && !$past(q.ra0);
  endproperty
  a_obirq: assert property (p_obirq)
    else $error("output empty request without data read");

  property p_ibirq;
    inbound_full_irq_out[0] |-> q.ibf[0];
  endproperty
  a_ibirq: assert property (p_ibirq)
    else $error("input full request without full flag");

  property p_ibf_hold;
    q.ibf[0] && !(fw_rd_in && fw_addr_in == mcbp_pkg::R_INB0)
      |=> q.ibf[0];
  endproperty
  a_ibf_hold: assert property (p_ibf_hold)
    else $error("input full cleared without firmware read");

  property p_usr;
    fw_wr_in && fw_addr_in == mcbp_pkg::R_STAT0
      |=> q.u0 == ($past(fw_wdata_in) & mcbp_pkg::USR_MASK);
  endproperty
  a_usr: assert property (p_usr)
    else $error("status firmware flags wrong after write");

  property p_latch;
    inbound_full_irq_out[0] |-> q.ib0 == $past(q.fq0[7:0])
      && q.a0l[0] == $past(q.fq0[8]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("input buffer or select flag not latched");

  // Ready still shows its reset low on the first edge out of reset
  property p_ready;
    $past(rst_n) |-> host_ready_out == (q.cnt != mcbp_pkg::FIFO_FULL);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready does not match buffer fill");

  c_hwrite: cover property (inbound_full_irq_out[0]);
  c_hread: cover property (outbound_empty_irq_out[0]);
  c_full: cover property (q.cnt == mcbp_pkg::FIFO_FULL);
  c_dbl: cover property (inbound_full_irq_out[1]);
endmodule : mcbp_port
`default_nettype wire

/* mcbp_master.sv */
// Behavioural master CPU driving the host side of the slave port
`default_nettype none
module mcbp_master (
  input wire logic clk_in,
  input wire logic oe_in,
  input wire logic [7:0] bus_in,
  output logic w_n_out,
  output logic r_n_out,
  output logic cs0_n_out,
  output logic cs1_n_out,
  output logic a0_out,
  output logic [7:0] d_out,
  output logic d_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rw_mode = 1'b0;
  // Release strobes, selects and the data pins
  task automatic idle;
    w_n_out = 1'b1;
    r_n_out = 1'b1;
    cs0_n_out = 1'b1;
    cs1_n_out = 1'b1;
    d_oe_out = 1'b0;
  endtask
  // One select per cycle; the other set stays deselected
  task automatic sel(input logic s, input logic a);
    @(negedge clk_in);
    cs0_n_out = s;
    cs1_n_out = !s;
    a0_out = a;
  endtask
  // Strobes held long, since the pin filter lags several cycles
  task automatic wr(input logic s, input logic a, input logic [7:0] d);
    sel(s, a);
    d_out = d;
    d_oe_out = 1'b1;
    r_n_out = !rw_mode; // Direction low means write
    w_n_out = 1'b0;
    repeat (10) @(negedge clk_in);
    idle();
    repeat (6) @(negedge clk_in);
  endtask
  // Hold the read until the port drives, then take the data
  task automatic rd(input logic s, input logic a, output logic [7:0] d);
    int n;
    sel(s, a);
    r_n_out = rw_mode;
    w_n_out = !rw_mode;
    n = 0;
    while (oe_in !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    d = bus_in;
    idle();
    repeat (6) @(negedge clk_in);
  endtask
  initial begin
    a0_out = 1'b0;
    d_out = 8'h00;
    idle();
  end
endmodule // mcbp_master
`default_nettype wire

/* tb.sv */
// Self-checking bench for the master CPU slave bus port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, fwr = 1'b0, frd = 1'b0;
  logic [2:0] fa = 3'h0;
  logic [7:0] fwd = 8'h00, v;
  logic w_n, r_n, c0, c1, a0, moe, doe, rdy, en, sec, thr;
  logic [7:0] mdo, dd, frdata, bus;
  logic [1:0] ibi, obi;
  int failures = 0, n_tests = 0, ib0 = 0, ib1 = 0, ob0 = 0, ob1 = 0;
  // Bus level; undriven it shows the inverse of the master's last word
  assign bus = doe ? dd : moe ? mdo : ~mdo;
  always #5 clk = !clk;
  // Pulses last one cycle, so count them at every edge
  always @(posedge clk) begin
    ib0 <= ib0 + int'(ibi[0]);
    ib1 <= ib1 + int'(ibi[1]);
    ob0 <= ob0 + int'(obi[0]);
    ob1 <= ob1 + int'(obi[1]);
  end
  mcbp_port i_mcbp_port (.clk_in(clk), .nrst_in(nrst), .write_n_in(w_n),
    .read_n_in(r_n), .chip_select_first_n_in(c0),
    .chip_select_second_n_in(c1), .register_select_line_in(a0),
    .host_data_pins_in(bus), .host_data_pins_out(dd),
    .host_data_pins_oe_out(doe), .host_ready_out(rdy), .fw_addr_in(fa),
    .fw_wr_in(fwr), .fw_rd_in(frd), .fw_wdata_in(fwd),
    .fw_rdata_out(frdata), .inbound_full_irq_out(ibi),
    .outbound_empty_irq_out(obi), .master_bus_port_en_out(en),
    .second_select_port_pin_used_out(sec),
    .input_threshold_select_out(thr));
  mcbp_master i_mcbp_master (.clk_in(clk), .oe_in(doe), .bus_in(bus),
    .w_n_out(w_n), .r_n_out(r_n), .cs0_n_out(c0), .cs1_n_out(c1),
    .a0_out(a0), .d_out(mdo), .d_oe_out(moe));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fw_w(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    fa = a;
    fwd = d;
    fwr = 1'b1;
    @(negedge clk);
    fwr = 1'b0;
  endtask
  // Read data stands for the cycle after the strobe only
  task automatic fw_r(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    fa = a;
    frd = 1'b1;
    @(negedge clk);
    frd = 1'b0;
    d = frdata;
  endtask
  task automatic t_enable;
    fw_r(mcbp_pkg::R_CTRL0, v);
    chk("ctrl0 reset", v, 8'h00);
    chk("oe idle", {7'h0, doe}, 8'h00);
    fw_w(mcbp_pkg::R_CTRL0, 8'h80);
    fw_w(mcbp_pkg::R_CTRL1, 8'h80);
    fw_w(mcbp_pkg::R_PCTRL, 8'h80);
    repeat (6) @(negedge clk);
    chk("enable", {7'h0, en}, 8'h01);
    chk("double", {7'h0, sec}, 8'h01);
    chk("ttl", {7'h0, thr}, 8'h01);
    $display("test enable done");
  endtask
  task automatic t_write;
    i_mcbp_master.wr(1'b0, 1'b1, 8'hA5);
    repeat (4) @(negedge clk);
    chk("in irq0", 8'(ib0), 8'h01);
    fw_r(mcbp_pkg::R_STAT0, v);
    chk("stat0 full", v, 8'h0A);
    fw_r(mcbp_pkg::R_INB0, v);
    chk("inb0", v, 8'hA5);
    fw_r(mcbp_pkg::R_STAT0, v);
    chk("stat0 read", v, 8'h08);
    fw_w(mcbp_pkg::R_STAT0, 8'hFF);
    fw_r(mcbp_pkg::R_STAT0, v);
    chk("stat0 user", v, 8'hFC);
    $display("test write done");
  endtask
  task automatic t_out;
    fw_w(mcbp_pkg::R_INB1, 8'h3C);
    i_mcbp_master.rd(1'b1, 1'b1, v);
    chk("host stat1", v, 8'h01);
    i_mcbp_master.rd(1'b1, 1'b0, v);
    chk("host data1", v, 8'h3C);
    chk("out irq1", 8'(ob1), 8'h01);
    chk("oe off", {7'h0, doe}, 8'h00);
    fw_r(mcbp_pkg::R_STAT1, v);
    chk("stat1 empty", v, 8'h00);
    $display("test read done");
  endtask
  // Three words with no firmware read: buffer fills, then drains in order
  task automatic t_buf;
    for (int i = 1; i <= 3; i++) i_mcbp_master.wr(1'b1, 1'b0, 8'(i * 17));
    chk("ready full", {7'h0, rdy}, 8'h00);
    for (int i = 1; i <= 3; i++) begin
      fw_r(mcbp_pkg::R_INB1, v);
      chk("inb1 order", v, 8'(i * 17));
      repeat (3) @(negedge clk);
    end
    chk("ready again", {7'h0, rdy}, 8'h01);
    chk("in irq1", 8'(ib1), 8'h03);
    $display("test buffer done");
  endtask
  task automatic t_rw;
    fw_w(mcbp_pkg::R_CTRL1, 8'h81);
    i_mcbp_master.rw_mode = 1'b1;
    repeat (6) @(negedge clk);
    i_mcbp_master.wr(1'b0, 1'b0, 8'hC3);
    repeat (4) @(negedge clk);
    fw_r(mcbp_pkg::R_INB0, v);
    chk("rw write", v, 8'hC3);
    fw_w(mcbp_pkg::R_INB0, 8'h5A);
    i_mcbp_master.rd(1'b0, 1'b0, v);
    chk("rw read", v, 8'h5A);
    chk("out irq0", 8'(ob0), 8'h01);
    // Single mode: a master using only the second select reaches nothing
    fw_w(mcbp_pkg::R_CTRL1, 8'h01);
    i_mcbp_master.wr(1'b1, 1'b0, 8'h77);
    repeat (4) @(negedge clk);
    chk("single sel1", 8'(ib1), 8'h03);
    chk("single mode", {7'h0, sec}, 8'h00);
    fw_r(mcbp_pkg::R_STAT1, v);
    chk("stat1 single", v, 8'h00);
    $display("test direction line done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    $display("[ERR] watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_enable();
    t_write();
    t_out();
    t_buf();
    t_rw();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
